//--- tebf_framing.sv
// Target-side start/stop detection, byte framing and acknowledge for a two-wire memory.
//
// What this block does
// - The data line may only change while the serial clock is low, for both the controller and this device.
// - Any data change while the clock is high is a start or stop, never a data bit.
// - Data falling with clock high is a start; everything before a start is ignored.
// - Data rising with clock high is a stop that ends the transaction.
// - A stop after a read puts the device into standby.
// - Words are 8 bits; each received word is acknowledged by a low data line in the ninth clock unless the FIFO is full or an earlier word was refused.
// - Standby is entered at power-up and after a stop once any internal write has completed.
// - Data is sampled on the rising clock edge and driven data changes after the falling edge.
// - The address word after a start is compared; a match is acknowledged, a miss returns to standby.
// - During the self-timed write after a write's stop the device ignores the bus.
`timescale 1ns/1ps
module tebf_framing
    import tebf_pkg::*;
#(
    parameter int unsigned WR_COUNT = tebf_pkg::WR_CYCLES,
    parameter logic [6:0]  ADDR     = tebf_pkg::DEV_ADDR
) (
    // System clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Two-wire link
    input  wire logic       scl,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Received words
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    // Words to send
    input  wire logic [7:0] tx_data,
    output logic            tx_taken,
    // Status
    output logic            standby,
    output logic            write_busy
);
    import tebf_pkg::*;

    tebf_state_e state_reg;
    logic [1:0]  scl_sync_reg;
    logic [1:0]  sda_sync_reg;
    logic [1:0]  bit_sync_reg;
    logic        scl_prev_reg;
    logic        sda_prev_reg;
    logic        link_bit;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;
    logic        rise_seen_reg;
    logic        bit_ev;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  shift_next;
    logic [7:0]  tx_shift_reg;
    logic        read_reg;
    logic        wrote_reg;
    logic        sda_oe_reg;
    logic [31:0] busy_cnt_reg;
    logic        fifo_ready;
    logic        push_reg;
    logic [7:0]  push_data_reg;
    logic        addr_match;

    // Data line sampled by the link clock itself at each rising edge.
    tebf_sampler u_sampler (
        .scl_clk (scl),
        .sda_i   (sda_i),
        .bit_o   (link_bit)
    );

    // Received words wait here; a full FIFO turns into a refused acknowledge.
    tebf_fifo #(
        .WIDTH (BYTE_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (push_reg),
        .in_ready  (fifo_ready),
        .in_data   (push_data_reg),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // Two-flop synchronisers for both pins and for the captured link bit.
    always_ff @(posedge clk) begin
        scl_sync_reg <= {scl_sync_reg[0], scl};
        sda_sync_reg <= {sda_sync_reg[0], sda_i};
        bit_sync_reg <= {bit_sync_reg[0], link_bit};
    end

    // Previous synchronised levels, for edge detection.
    always_ff @(posedge clk) begin
        if (reset) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    // Bus conditions: a data edge while the clock stays high is never a data bit.
    assign scl_rise = scl_sync_reg[1] && !scl_prev_reg;
    assign scl_fall = !scl_sync_reg[1] && scl_prev_reg;
    assign start_ev = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
    assign stop_ev  = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];
    // A bit counts only once its whole high phase has passed; the link bit is then long settled.
    assign bit_ev     = scl_fall && rise_seen_reg;
    assign shift_next = {shift_reg[6:0], bit_sync_reg[1]};
    assign addr_match = (shift_next[7:1] == ADDR);

    // Tracks whether a rising clock edge followed the last bus condition or falling clock edge.
    always_ff @(posedge clk) begin
        if (reset || start_ev || stop_ev) begin
            rise_seen_reg <= 1'b0;
        end else if (scl_rise) begin
            rise_seen_reg <= 1'b1;
        end else if (scl_fall) begin
            rise_seen_reg <= 1'b0;
        end
    end

    // Framing state machine.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= TEBF_IDLE;
        end else if (state_reg == TEBF_BUSY) begin
            if (busy_cnt_reg == 32'h1) begin
                state_reg <= TEBF_IDLE;
            end
        end else if (start_ev) begin
            state_reg <= TEBF_ADDR;
        end else if (stop_ev) begin
            state_reg <= wrote_reg ? TEBF_BUSY : TEBF_IDLE;
        end else if (bit_ev) begin
            unique case (state_reg)
                TEBF_IDLE, TEBF_WAIT: state_reg <= state_reg;
                TEBF_ADDR: begin
                    if (bit_cnt_reg == BIT_CNT_LAST) begin
                        state_reg <= addr_match ? TEBF_ACK : TEBF_IDLE;
                    end
                end
                TEBF_WRX: begin
                    if (bit_cnt_reg == BIT_CNT_LAST) begin
                        state_reg <= fifo_ready ? TEBF_ACK : TEBF_WAIT;
                    end
                end
                TEBF_ACK:  state_reg <= read_reg ? TEBF_RTX : TEBF_WRX;
                TEBF_RTX: begin
                    if (bit_cnt_reg == BIT_CNT_LAST) begin
                        state_reg <= TEBF_RACK;
                    end
                end
                TEBF_RACK: state_reg <= bit_sync_reg[1] ? TEBF_WAIT : TEBF_RTX;
                TEBF_BUSY: state_reg <= TEBF_BUSY;
            endcase
        end
    end

    // Bit counter and receive shifter, restarted by every start.
    always_ff @(posedge clk) begin
        if (reset || start_ev) begin
            bit_cnt_reg <= BIT_CNT_RST;
            shift_reg   <= '0;
        end else if (bit_ev) begin
            if ((state_reg == TEBF_ADDR || state_reg == TEBF_WRX || state_reg == TEBF_RTX)
                && bit_cnt_reg != BIT_CNT_LAST) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else begin
                bit_cnt_reg <= BIT_CNT_RST;
            end
            shift_reg <= shift_next;
        end
    end

    // Direction and write bookkeeping; a read address sets the direction for the transaction.
    always_ff @(posedge clk) begin
        if (reset || start_ev) begin
            read_reg  <= 1'b0;
            wrote_reg <= 1'b0;
        end else if (stop_ev) begin
            wrote_reg <= 1'b0;
        end else if (bit_ev && bit_cnt_reg == BIT_CNT_LAST) begin
            if (state_reg == TEBF_ADDR) begin
                read_reg <= shift_next[0];
            end
            if (state_reg == TEBF_WRX && fifo_ready) begin
                wrote_reg <= 1'b1;
            end
        end
    end

    // Accepted write words enter the FIFO one cycle after their last bit.
    always_ff @(posedge clk) begin
        if (reset) begin
            push_reg      <= 1'b0;
            push_data_reg <= '0;
        end else begin
            push_reg      <= bit_ev && state_reg == TEBF_WRX && bit_cnt_reg == BIT_CNT_LAST && fifo_ready;
            push_data_reg <= shift_next;
        end
    end

    // Transmit shifter: loaded at the end of an acknowledge, shifted after each falling edge within a read byte.
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_shift_reg <= '0;
            tx_taken     <= 1'b0;
        end else begin
            tx_taken <= 1'b0;
            if (bit_ev && ((state_reg == TEBF_ACK && read_reg) || (state_reg == TEBF_RACK && !bit_sync_reg[1]))) begin
                tx_shift_reg <= tx_data;
                tx_taken     <= 1'b1;
            end else if (bit_ev && state_reg == TEBF_RTX) begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end

    // Open-drain drive; only ever changed on a falling edge or a bus condition.
    always_ff @(posedge clk) begin
        if (reset || start_ev || stop_ev) begin
            sda_oe_reg <= 1'b0;
        end else if (bit_ev && state_reg != TEBF_BUSY) begin
            unique case (state_reg)
                TEBF_ADDR: sda_oe_reg <= (bit_cnt_reg == BIT_CNT_LAST) && addr_match;
                TEBF_WRX:  sda_oe_reg <= (bit_cnt_reg == BIT_CNT_LAST) && fifo_ready;
                TEBF_ACK:  sda_oe_reg <= read_reg && !tx_data[7];
                TEBF_RTX:  sda_oe_reg <= (bit_cnt_reg != BIT_CNT_LAST) && !tx_shift_reg[6];
                TEBF_RACK: sda_oe_reg <= !bit_sync_reg[1] && !tx_data[7];
                default:   sda_oe_reg <= 1'b0;
            endcase
        end
    end

    // Self-timed write cycle; inputs are ignored until it runs out.
    always_ff @(posedge clk) begin
        if (reset) begin
            busy_cnt_reg <= '0;
        end else if (state_reg != TEBF_BUSY && stop_ev && wrote_reg) begin
            busy_cnt_reg <= WR_COUNT;
        end else if (busy_cnt_reg != '0) begin
            busy_cnt_reg <= busy_cnt_reg - 32'h1;
        end
    end

    // The drive enable leaves straight from its flop; a second stage would push the edge past a short clock-low phase.
    assign sda_oe = sda_oe_reg;

    // Registered pin and status outputs.
    always_ff @(posedge clk) begin
        if (reset) begin
            sda_o      <= 1'b0;
            standby    <= 1'b1;
            write_busy <= 1'b0;
        end else begin
            sda_o      <= 1'b0;
            standby    <= (state_reg == TEBF_IDLE);
            write_busy <= (state_reg == TEBF_BUSY);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    oe_change_low_a: assert property ($changed(sda_oe_reg) |-> $past(scl_fall || start_ev || stop_ev))
        else $error("Drive changed outside a falling clock or bus condition.");
    start_restart_a: assert property (start_ev && state_reg != TEBF_BUSY |=> state_reg == TEBF_ADDR && bit_cnt_reg == 4'h0)
        else $error("Start did not restart address reception.");
    start_no_bit_a: assert property (start_ev || stop_ev
        |=> !rise_seen_reg && ($past(start_ev) ? shift_reg == 8'h00 : $stable(shift_reg)))
        else $error("Bus condition was taken as a data bit.");
    stop_ends_a: assert property (stop_ev && state_reg != TEBF_BUSY |=> (state_reg inside {TEBF_IDLE, TEBF_BUSY}) && !sda_oe_reg)
        else $error("Stop did not end the transaction.");
    read_standby_a: assert property (stop_ev && !wrote_reg && state_reg != TEBF_BUSY |=> ##1 standby)
        else $error("Stop after read did not reach standby.");
    idle_ignores_a: assert property (state_reg == TEBF_IDLE && !start_ev |=> state_reg == TEBF_IDLE)
        else $error("Traffic taken before a start.");
    addr_ack_a: assert property (state_reg == TEBF_ADDR && bit_ev && bit_cnt_reg == 4'h7 && addr_match
        |=> state_reg == TEBF_ACK && sda_oe_reg)
        else $error("Matching address not acknowledged.");
    addr_miss_a: assert property (state_reg == TEBF_ADDR && bit_ev && bit_cnt_reg == 4'h7 && !addr_match
        |=> state_reg == TEBF_IDLE && !sda_oe_reg)
        else $error("Missed address not released to standby.");
    ninth_ack_a: assert property (state_reg == TEBF_ACK && !start_ev && !stop_ev |-> sda_oe_reg)
        else $error("Acknowledge not held through the ninth clock.");
    busy_silent_a: assert property ($rose(state_reg == TEBF_BUSY) |-> (!sda_oe_reg && state_reg == TEBF_BUSY)[*8])
        else $error("Device answered during its write cycle.");
    power_up_a: assert property ($fell(reset) |-> standby && state_reg == TEBF_IDLE)
        else $error("Device not in standby after reset.");

    read_done_c:  cover property (state_reg == TEBF_RACK && bit_ev && bit_sync_reg[1]);
    write_push_c: cover property (push_reg);
    busy_c:       cover property ($rose(write_busy));
    full_nack_c:  cover property (state_reg == TEBF_WRX && bit_ev && bit_cnt_reg == 4'h7 && !fifo_ready);
endmodule

//--- tebf_pkg.sv
// Shared constants for the two-wire memory bus framing block.
package tebf_pkg;
    // Timing.
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned T_WR_NS       = 5000000;
    localparam int unsigned WR_CYCLES     = T_WR_NS / CLK_PERIOD_NS;
    // Framing.
    localparam int unsigned BYTE_BITS     = 8;
    localparam int unsigned FIFO_DEPTH    = 8;
    localparam logic [6:0]  DEV_ADDR      = 7'h50;
    localparam logic [3:0]  BIT_CNT_RST   = 4'h0;
    localparam logic [3:0]  BIT_CNT_LAST  = 4'h7;
    // Framing states.
    typedef enum logic [2:0] {
        TEBF_IDLE, TEBF_ADDR, TEBF_ACK, TEBF_WRX, TEBF_RTX, TEBF_RACK, TEBF_WAIT, TEBF_BUSY
    } tebf_state_e;
endpackage

//--- tebf_sampler.sv
// Link-clock side: captures the data line on each rising serial clock edge.
`timescale 1ns/1ps
module tebf_sampler (
    // Link
    input  wire logic scl_clk,
    input  wire logic sda_i,
    // Captured bit
    output logic      bit_o
);
    // Pure data flop: its value is only read after the clock side has seen a full high phase.
    always_ff @(posedge scl_clk) begin
        bit_o <= sda_i;
    end
endmodule

//--- tebf_fifo.sv
// Receive FIFO with a registered head word so the consumer sees flop outputs.
`timescale 1ns/1ps
module tebf_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;
    logic             head_load;

    // The array holds DEPTH-1 words behind the head register, so DEPTH in total.
    assign in_ready  = (count_reg != (AW+1)'(DEPTH - 1)) || head_load;
    assign push      = in_valid && in_ready;
    assign head_load = !out_valid || out_ready;
    assign pop       = head_load && (count_reg != '0);

    // Storage array and pointers.
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push && !(head_load && count_reg == '0)) begin
                mem[wr_ptr_reg] <= in_data;
                wr_ptr_reg      <= (wr_ptr_reg == AW'(DEPTH - 2)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 2)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !(head_load && count_reg == '0) && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !(push && !(head_load && count_reg == '0))) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Head register; an empty array lets a new word pass straight in.
    always_ff @(posedge clk) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (head_load) begin
            if (pop) begin
                out_valid <= 1'b1;
                out_data  <= mem[rd_ptr_reg];
            end else if (push) begin
                out_valid <= 1'b1;
                out_data  <= in_data;
            end else begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

//--- tebf_ctl_model.sv
// Behavioural two-wire bus controller that drives the serial clock and pulls the data line.
`timescale 1ns/1ps
module tebf_ctl_model (
    // Link
    output logic      scl,
    output logic      sda_pull_low,
    // Resolved wire level
    input  wire logic sda
);
    localparam int HALF_NS = 80;
    localparam int QTR_NS  = 40;

    // The clock rests high between frames and the data line is left to the pull-up.
    initial begin
        scl          = 1'b1;
        sda_pull_low = 1'b0;
    end

    // One clock; data moves mid-low so the device's synchronisers never see it race the clock.
    task automatic put_bit(input logic b, output logic r);
        scl = 1'b0;
        #QTR_NS;
        sda_pull_low = !b;
        #QTR_NS;
        scl = 1'b1;
        #(HALF_NS - 10);
        r = sda;
        #10;
    endtask

    // Data falls while the clock is high; a released line is restored first.
    task automatic start();
        if (sda_pull_low || !scl) begin
            scl = 1'b0;
            #QTR_NS;
            sda_pull_low = 1'b0;
            #QTR_NS;
            scl = 1'b1;
        end
        #QTR_NS;
        sda_pull_low = 1'b1;
        #QTR_NS;
    endtask

    // Data rises while the clock is high; the clock then stays high.
    task automatic stop();
        scl = 1'b0;
        #QTR_NS;
        sda_pull_low = 1'b1;
        #QTR_NS;
        scl = 1'b1;
        #QTR_NS;
        sda_pull_low = 1'b0;
        #HALF_NS;
    endtask

    // Eight bits MSB first, then a released ninth clock that reads the acknowledge.
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(d[i], r);
        put_bit(1'b1, r);
        ack = !r;
    endtask

    // Eight bits read from the device, then our own acknowledge or refusal.
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(!more, r);
    endtask

    // Up to nine clocks until the line reads high, then a start.
    task automatic recover();
        logic r;
        r = 1'b0;
        for (int i = 0; i < 9 && !r; i++) put_bit(1'b1, r);
        start();
    endtask
endmodule

//--- twowire_eeprom_bus_framing_tb.sv
// Self-checking bench for the two-wire memory framing block against a controller model.
`timescale 1ns/1ps
module twowire_eeprom_bus_framing_tb;
    import tebf_pkg::*;
    localparam int unsigned WR_SIM  = 200;
    localparam logic [7:0]  ADDR_WR = {DEV_ADDR, 1'b0};
    localparam logic [7:0]  ADDR_RD = {DEV_ADDR, 1'b1};

    logic        clk;
    logic        reset;
    logic        scl;
    logic        ctl_low;
    logic        sda_line;
    logic        sda_o;
    logic        sda_oe;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_ready;
    logic [7:0]  tx_data;
    logic        tx_taken;
    logic        standby;
    logic        write_busy;
    int          error_cnt;
    int          cmp_count;
    int          busy_cnt;
    logic [31:0] lfsr;
    logic [7:0]  rx_q[$];
    logic [7:0]  tx_q[$];
    logic [7:0]  exp_rd[$];

    // Open-drain wire with a pull-up: low if either party pulls it.
    assign sda_line = !(ctl_low || (sda_oe && !sda_o));

    tebf_framing #(.WR_COUNT(WR_SIM), .ADDR(DEV_ADDR)) dut (
        .clk(clk), .reset(reset), .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_taken(tx_taken), .standby(standby), .write_busy(write_busy)
    );
    tebf_ctl_model ctl (.scl(scl), .sda_pull_low(ctl_low), .sda(sda_line));

    // System clock, 25 ns period.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Length of the self-timed write, counted in system clocks.
    always @(posedge clk) begin
        if (write_busy === 1'b1) busy_cnt <= busy_cnt + 1;
    end

    // Each captured read byte becomes the expected one, and the next is offered at once.
    always @(negedge clk) begin
        if (tx_taken === 1'b1 && tx_q.size() != 0) begin
            exp_rd.push_back(tx_q.pop_front());
            tx_data = (tx_q.size() != 0) ? tx_q[0] : 8'hff;
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait for the write-cycle flag to reach a level.
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (write_busy !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk_flag(write_busy, lvl);
    endtask

    // Drain the buffer with a randomly stalling consumer; a word leaves at the edge after ready.
    task automatic drain(input int lim);
        int n;
        n = 0;
        while (rx_q.size() != 0 && n < lim) begin
            @(negedge clk);
            lfsr = lfsr_next(lfsr);
            rx_ready = lfsr[0] | lfsr[1];
            if (rx_ready && rx_valid === 1'b1) chk_word(rx_data, rx_q.pop_front());
            n++;
        end
        chk_word(8'(rx_q.size()), 8'h00);
        @(negedge clk);
        rx_ready = 1'b0;
        chk_flag(rx_valid, 1'b0);
    endtask

    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog sized well above the few tens of microseconds the sequence needs.
    initial begin
        #2000000;
        error_cnt++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_of_test();
    end

    initial begin
        logic       ack;
        logic [7:0] d;
        reset = 1'b1;
        rx_ready = 1'b0;
        tx_data = 8'h00;
        lfsr = 32'h5d87e3eb;
        error_cnt = 0;
        cmp_count = 0;
        busy_cnt = 0;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk_flag(standby, 1'b1);
        chk_flag(sda_oe, 1'b0);
        chk_flag(write_busy, 1'b0);
        chk_flag(rx_valid, 1'b0);
        repeat (4) @(negedge clk);
        $display("test reset done");
        // A word without a start, then recovery and a foreign address.
        ctl.send_byte(ADDR_WR, ack);
        chk_flag(ack, 1'b0);
        ctl.recover();
        ctl.send_byte(ADDR_WR ^ 8'h10, ack);
        chk_flag(ack, 1'b0);
        chk_flag(standby, 1'b1);
        ctl.stop();
        $display("test ignore done");
        // Write until the full buffer refuses, then poll during the write cycle.
        ctl.start();
        ctl.send_byte(ADDR_WR, ack);
        chk_flag(ack, 1'b1);
        for (int i = 0; i < 9; i++) begin
            lfsr = lfsr_next(lfsr);
            d = lfsr[7:0];
            ctl.send_byte(d, ack);
            chk_flag(ack, i < 8);
            if (i < 8) rx_q.push_back(d);
        end
        busy_cnt = 0;
        ctl.stop();
        wait_busy(1'b1, 20);
        ctl.start();
        ctl.send_byte(ADDR_WR, ack);
        chk_flag(ack, 1'b0);
        ctl.stop();
        wait_busy(1'b0, WR_SIM + 20);
        chk_word(busy_cnt[7:0], WR_SIM[7:0]);
        repeat (2) @(negedge clk);
        chk_flag(standby, 1'b1);
        drain(600);
        $display("test write done");
        // A start in mid-word restarts at the address word.
        ctl.start();
        ctl.send_byte(ADDR_WR, ack);
        chk_flag(ack, 1'b1);
        repeat (4) ctl.put_bit(1'b0, ack);
        ctl.start();
        ctl.send_byte(ADDR_WR, ack);
        chk_flag(ack, 1'b1);
        lfsr = lfsr_next(lfsr);
        d = lfsr[7:0];
        ctl.send_byte(d, ack);
        chk_flag(ack, 1'b1);
        rx_q.push_back(d);
        ctl.stop();
        wait_busy(1'b1, 20);
        wait_busy(1'b0, WR_SIM + 20);
        drain(200);
        $display("test restart done");
        // Read three bytes, the last one refused by the controller.
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            tx_q.push_back(lfsr[15:8]);
        end
        @(negedge clk);
        tx_data = tx_q[0];
        ctl.start();
        ctl.send_byte(ADDR_RD, ack);
        chk_flag(ack, 1'b1);
        for (int i = 0; i < 3; i++) begin
            ctl.recv_byte(i < 2, d);
            chk_word(d, exp_rd.size() != 0 ? exp_rd.pop_front() : ~d);
        end
        ctl.stop();
        repeat (4) @(negedge clk);
        chk_flag(standby, 1'b1);
        chk_flag(write_busy, 1'b0);
        chk_word(8'(tx_q.size()), 8'h01);
        chk_flag(sda_o, 1'b0);
        $display("test read done");
        end_of_test();
    end
endmodule
